// [core/dpu_top.sv]
// Director prefetch unit: address steering, director fetch, look-ahead and execution
//
// Summary of operation
// - Scanner priority: data references first, director fetches second, processor last except right after a director fetch.
// - With buffer full or loading stopped, processor gets every scanner slot not taken by a data reference.
// - Address elements are 16 bits; only the low 12 reach memory.
// - Director address drives memory by default and increments after every fetch but a branch's second word.
// - Executing an unconditional branch loads the director address from the director.
// - Conditional target is held; copied to director address only when condition met.
// - Data address loads from address director, drives transfers, increments per word.
// - Final address mux follows the grant: processor address or controller address.
// - Director buffer is a sixteen-entry, 32-bit circular queue with two pointers.
// - Full and empty flags from pointer increments; blocked side cannot move.
// - Channel 8 function 0020 empties the buffer and zeroes the director address.
// - Function 0018 starts or restarts loading from the current director address.
// - Function 0022 extracts oldest director; if empty, next loaded one executes.
// - Entries fill from two fetches, upper first; pointer advances after lower half.
// - First 15 bits of each first half are decoded during fetch.
// - Fetched unconditional branch skips buffer; its second word becomes director address.
// - Fetched stop director skips buffer, halts loading, director address plus one.
// - Fetched terminate is stored and pointer advanced at once; next word starts anew.
// - Address director takes two entries; next three words bypass the decode.
// - Next director is staged in the output register while current one executes.
// - Data director completes at setup; another data director waits for transfer end.
// - Executing an address director keeps its second entry from being decoded.
// - Terminate stops extraction; next 0022 resumes at the following entry.
`timescale 1ns/10ps
module dpu_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic [dpu_pkg::MEM_AW-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [dpu_pkg::WORD_W-1:0] mem_rdata,
  input wire logic proc_req,
  input wire logic [dpu_pkg::ADDR_W-1:0] proc_addr,
  output logic proc_ack,
  output logic [dpu_pkg::WORD_W-1:0] proc_rdata
);
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] func;
    logic [15:0] dar;
    logic [15:0] cbar;
    logic [15:0] daddr;
    logic [15:0] wcnt;
    logic [31:0] outreg;
    logic outv;
    logic busy;
    logic xfer;
    logic run;
    logic loading;
    logic skip;
    dpu_pkg::dpu_fetch_t fst;
    logic mreq;
    logic [11:0] maddr;
    dpu_pkg::dpu_src_t msrc;
    logic dir_last;
    logic proc_ack;
    logic [15:0] proc_rdata;
  } dpu_st_t;

  dpu_st_t st_ff;
  dpu_st_t nxt_st;

  logic buf_clr;
  logic buf_we_hi;
  logic buf_we_lo;
  logic buf_adv_in;
  logic buf_adv_out;
  logic [31:0] buf_rdata;
  logic [3:0] buf_in_ptr;
  logic [3:0] buf_out_ptr;
  logic buf_full;
  logic buf_empty;
  logic gnt_data;
  logic gnt_dir;
  logic gnt_proc;
  logic dir_req;
  logic data_req;
  logic apb_setup;
  logic apb_wr;
  logic [14:0] fetch_op;
  logic [14:0] exec_op;
  logic started;
  logic [31:0] status;

  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == dpu_pkg::OFS_STATUS) || (a == dpu_pkg::OFS_DIR_ADDR) ||
                 (a == dpu_pkg::OFS_COND_ADDR) || (a == dpu_pkg::OFS_DATA_ADDR) ||
                 (a == dpu_pkg::OFS_OUT_REG) || (a == dpu_pkg::OFS_EXEC_CTRL) ||
                 (a == dpu_pkg::OFS_FUNC);
  endfunction

  function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] ofs);
    wr_hit = en && (a == ofs);
  endfunction

  dpu_dbuf u_dbuf (
    .mclk(mclk),
    .arst_n(arst_n),
    .clr(buf_clr),
    .we_hi(buf_we_hi),
    .we_lo(buf_we_lo),
    .wdata(mem_rdata),
    .adv_in(buf_adv_in),
    .adv_out(buf_adv_out),
    .rdata(buf_rdata),
    .in_ptr(buf_in_ptr),
    .out_ptr(buf_out_ptr),
    .full(buf_full),
    .empty(buf_empty)
  );

  // no director request while full or stopped, so the processor gets every slot that data references leave
  assign dir_req = st_ff.loading && !buf_full;
  assign data_req = st_ff.xfer;

  dpu_scan u_scan (
    .idle(!st_ff.mreq),
    .data_req(data_req),
    .dir_req(dir_req),
    .proc_req(proc_req && !st_ff.proc_ack),
    .dir_last(st_ff.dir_last),
    .gnt_data(gnt_data),
    .gnt_dir(gnt_dir),
    .gnt_proc(gnt_proc)
  );

  always_comb begin
    status = 32'h0000_0000;
    status[dpu_pkg::ST_IN_PTR +: 4] = buf_in_ptr;
    status[dpu_pkg::ST_OUT_PTR +: 4] = buf_out_ptr;
    status[dpu_pkg::ST_EMPTY] = buf_empty;
    status[dpu_pkg::ST_FULL] = buf_full;
    status[dpu_pkg::ST_LOADING] = st_ff.loading;
    status[dpu_pkg::ST_RUN] = st_ff.run;
    status[dpu_pkg::ST_OUTV] = st_ff.outv;
    status[dpu_pkg::ST_BUSY] = st_ff.busy;
    status[dpu_pkg::ST_XFER] = st_ff.xfer;
    status[dpu_pkg::ST_SKIP] = st_ff.skip;
  end

  always_comb begin
    nxt_st = st_ff;
    buf_clr = 1'b0;
    buf_we_hi = 1'b0;
    buf_we_lo = 1'b0;
    buf_adv_in = 1'b0;
    buf_adv_out = 1'b0;
    started = 1'b0;
    fetch_op = mem_rdata[14:0];
    exec_op = st_ff.outreg[30:16];
    nxt_st.proc_ack = 1'b0;

    // APB: zero wait states, read data captured in the setup cycle
    apb_setup = psel && !penable;
    apb_wr = psel && penable && st_ff.pready && pwrite && !st_ff.pslverr;
    nxt_st.pready = apb_setup;
    nxt_st.pslverr = apb_setup && !reg_mapped(paddr);
    nxt_st.prdata = 32'h0000_0000;
    if (apb_setup && !pwrite) begin
      unique case (paddr)
        dpu_pkg::OFS_STATUS: nxt_st.prdata = status;
        dpu_pkg::OFS_DIR_ADDR: nxt_st.prdata = {16'h0000, st_ff.dar};
        dpu_pkg::OFS_COND_ADDR: nxt_st.prdata = {16'h0000, st_ff.cbar};
        dpu_pkg::OFS_DATA_ADDR: nxt_st.prdata = {16'h0000, st_ff.daddr};
        dpu_pkg::OFS_OUT_REG: nxt_st.prdata = st_ff.outreg;
        dpu_pkg::OFS_EXEC_CTRL: nxt_st.prdata = {16'h0000, st_ff.wcnt};
        dpu_pkg::OFS_FUNC: nxt_st.prdata = {16'h0000, st_ff.func};
        default: nxt_st.prdata = 32'h0000_0000;
      endcase
    end

    // Memory cycle: the request holds until the memory answers
    if (st_ff.mreq) begin
      if (mem_ack) begin
        nxt_st.mreq = 1'b0;
        nxt_st.dir_last = (st_ff.msrc == dpu_pkg::SRC_DIR);
        unique case (st_ff.msrc)
          dpu_pkg::SRC_DATA: begin
            // one increment per transferred word until the count runs out
            nxt_st.daddr = st_ff.daddr + 16'h0001;
            nxt_st.wcnt = st_ff.wcnt - 16'h0001;
            if (st_ff.wcnt <= 16'h0001) begin
              nxt_st.xfer = 1'b0;
            end
          end
          dpu_pkg::SRC_DIR: begin
            // A word still in flight at master clear is dropped
            if (st_ff.loading) begin
              nxt_st.dar = st_ff.dar + 16'h0001;
              unique case (st_ff.fst)
                dpu_pkg::F_FIRST: begin
                  // function code decoded before the word is stored
                  if (fetch_op == dpu_pkg::OP_UBRANCH) begin
                    nxt_st.fst = dpu_pkg::F_UBR;
                  end else if (fetch_op == dpu_pkg::OP_STOP) begin
                    // halt loading, address already advanced by one
                    nxt_st.loading = 1'b0;
                  end else begin
                    buf_we_hi = 1'b1;
                    if (fetch_op == dpu_pkg::OP_TERM) begin
                      buf_adv_in = 1'b1;
                    end else if (fetch_op == dpu_pkg::OP_ADDR) begin
                      // next three words bypass the decode
                      nxt_st.fst = dpu_pkg::F_ADDR_LO;
                    end else begin
                      nxt_st.fst = dpu_pkg::F_SECOND;
                    end
                  end
                end
                dpu_pkg::F_SECOND: begin
                  // pointer moves once the lower half is stored
                  buf_we_lo = 1'b1;
                  buf_adv_in = 1'b1;
                  nxt_st.fst = dpu_pkg::F_FIRST;
                end
                dpu_pkg::F_UBR: begin
                  // second word becomes the fetch address
                  nxt_st.dar = mem_rdata;
                  nxt_st.fst = dpu_pkg::F_FIRST;
                end
                dpu_pkg::F_ADDR_LO: begin
                  buf_we_lo = 1'b1;
                  buf_adv_in = 1'b1;
                  nxt_st.fst = dpu_pkg::F_ADDR_HI;
                end
                dpu_pkg::F_ADDR_HI: begin
                  buf_we_hi = 1'b1;
                  nxt_st.fst = dpu_pkg::F_SECOND;
                end
                default: nxt_st.fst = dpu_pkg::F_FIRST;
              endcase
            end
          end
          dpu_pkg::SRC_PROC: begin
            nxt_st.proc_ack = 1'b1;
            nxt_st.proc_rdata = mem_rdata;
          end
          default: nxt_st.mreq = 1'b0;
        endcase
      end
    end else if (gnt_data || gnt_dir || gnt_proc) begin
      nxt_st.mreq = 1'b1;
      // processor address only on a processor grant
      // low 12 bits of the 16-bit address reach memory
      if (gnt_proc) begin
        nxt_st.msrc = dpu_pkg::SRC_PROC;
        nxt_st.maddr = proc_addr[11:0];
      end else if (gnt_data) begin
        nxt_st.msrc = dpu_pkg::SRC_DATA;
        nxt_st.maddr = st_ff.daddr[11:0];
      end else begin
        nxt_st.msrc = dpu_pkg::SRC_DIR;
        nxt_st.maddr = st_ff.dar[11:0];
      end
    end

    // Execution stage: the director in the output register starts when allowed
    if (st_ff.outv && !st_ff.busy && !(exec_op == dpu_pkg::OP_DATA && st_ff.xfer)) begin
      started = 1'b1;
      nxt_st.outv = 1'b0;
      if (exec_op == dpu_pkg::OP_UBRANCH) begin
        // new fetch address straight from the director
        nxt_st.dar = st_ff.outreg[15:0];
      end else if (exec_op == dpu_pkg::OP_CBRANCH) begin
        // target held until the condition is reported
        nxt_st.cbar = st_ff.outreg[15:0];
      end else if (exec_op == dpu_pkg::OP_TERM) begin
        // no further extraction until the next execute function
        nxt_st.run = 1'b0;
      end else if (exec_op == dpu_pkg::OP_ADDR) begin
        // next entry is operand, not a director
        nxt_st.skip = 1'b1;
      end else if (exec_op == dpu_pkg::OP_DATA) begin
        // complete once count and address are set up
        nxt_st.wcnt = st_ff.outreg[15:0];
        nxt_st.xfer = (st_ff.outreg[15:0] != 16'h0000);
      end else begin
        nxt_st.busy = 1'b1;
      end
    end

    // stage the next director while the current one executes
    // waits in run state until a director is loaded
    if (st_ff.run && !st_ff.outv && !buf_empty) begin
      buf_adv_out = 1'b1;
      if (st_ff.skip) begin
        // data address from the address field of the second entry
        nxt_st.daddr = buf_rdata[31:16];
        nxt_st.skip = 1'b0;
      end else begin
        nxt_st.outreg = buf_rdata;
        nxt_st.outv = 1'b1;
      end
    end

    if (wr_hit(apb_wr, paddr, dpu_pkg::OFS_EXEC_CTRL)) begin
      // A director starting in this cycle keeps busy: the set wins over the clear
      if (pwdata[dpu_pkg::EXC_DONE_BIT] && !started) begin
        nxt_st.busy = 1'b0;
      end
      // condition met, the held target becomes the fetch address
      if (pwdata[dpu_pkg::EXC_COND_BIT]) begin
        nxt_st.dar = st_ff.cbar;
      end
    end

    if (wr_hit(apb_wr, paddr, dpu_pkg::OFS_FUNC)) begin
      nxt_st.func = pwdata[15:0];
      if (pwdata[15:0] == dpu_pkg::FN_MCLEAR) begin
        // empty buffer and halt loading; the next load fetches from location zero
        buf_clr = 1'b1;
        buf_adv_out = 1'b0;
        nxt_st.dar = 16'h0000;
        nxt_st.loading = 1'b0;
        nxt_st.run = 1'b0;
        nxt_st.outv = 1'b0;
        nxt_st.busy = 1'b0;
        nxt_st.skip = 1'b0;
        nxt_st.fst = dpu_pkg::F_FIRST;
      end else if (pwdata[15:0] == dpu_pkg::FN_LOAD) begin
        // resume from the current director address
        nxt_st.loading = 1'b1;
      end else if (pwdata[15:0] == dpu_pkg::FN_EXEC) begin
        nxt_st.run = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign mem_req = st_ff.mreq;
  assign mem_addr = st_ff.maddr;
  assign proc_ack = st_ff.proc_ack;
  assign proc_rdata = st_ff.proc_rdata;
endmodule

// [core/dpu_pkg.sv]
// Shared constants and types for the director prefetch unit
package dpu_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_DIR_ADDR = 8'h04;
  localparam logic [7:0] OFS_COND_ADDR = 8'h08;
  localparam logic [7:0] OFS_DATA_ADDR = 8'h0C;
  localparam logic [7:0] OFS_OUT_REG = 8'h10;
  localparam logic [7:0] OFS_EXEC_CTRL = 8'h14;
  localparam logic [7:0] OFS_FUNC = 8'h20;
  // EXEC_CTRL write bits
  localparam int EXC_DONE_BIT = 0;
  localparam int EXC_COND_BIT = 1;
  // Function codes on the normal output channel
  localparam logic [15:0] FN_MCLEAR = 16'h0020;
  localparam logic [15:0] FN_LOAD = 16'h0018;
  localparam logic [15:0] FN_EXEC = 16'h0022;
  // Director function codes, first 15 bits of the first half
  localparam logic [14:0] OP_UBRANCH = 15'h0001;
  localparam logic [14:0] OP_CBRANCH = 15'h0002;
  localparam logic [14:0] OP_STOP = 15'h0003;
  localparam logic [14:0] OP_TERM = 15'h0004;
  localparam logic [14:0] OP_ADDR = 15'h0005;
  localparam logic [14:0] OP_DATA = 15'h0006;
  // Sizes
  localparam int ADDR_W = 16;
  localparam int MEM_AW = 12;
  localparam int WORD_W = 16;
  localparam int DIR_W = 32;
  localparam int BUF_DEPTH = 16;
  localparam int PTR_W = 4;
  // Status field positions
  localparam int ST_IN_PTR = 0;
  localparam int ST_OUT_PTR = 4;
  localparam int ST_EMPTY = 8;
  localparam int ST_FULL = 9;
  localparam int ST_LOADING = 10;
  localparam int ST_RUN = 11;
  localparam int ST_OUTV = 12;
  localparam int ST_BUSY = 13;
  localparam int ST_XFER = 14;
  localparam int ST_SKIP = 15;

  typedef enum logic [2:0] {
    F_FIRST,
    F_SECOND,
    F_UBR,
    F_ADDR_LO,
    F_ADDR_HI
  } dpu_fetch_t;

  typedef enum logic [1:0] {
    SRC_DATA,
    SRC_DIR,
    SRC_PROC
  } dpu_src_t;
endpackage

// [core/dpu_scan.sv]
// Memory scanner grant selection for data, director and processor references
`timescale 1ns/10ps
module dpu_scan (
  input wire logic idle,
  input wire logic data_req,
  input wire logic dir_req,
  input wire logic proc_req,
  input wire logic dir_last,
  output logic gnt_data,
  output logic gnt_dir,
  output logic gnt_proc
);
  always_comb begin
    gnt_data = 1'b0;
    gnt_dir = 1'b0;
    gnt_proc = 1'b0;
    if (idle) begin
      if (data_req) begin
        gnt_data = 1'b1;
      end else if (dir_req && !(proc_req && dir_last)) begin
        // Directors yield one slot after each fetch so the processor is never starved
        gnt_dir = 1'b1;
      end else if (proc_req) begin
        gnt_proc = 1'b1;
      end
    end
  end
endmodule

// [core/dpu_dbuf.sv]
// Circular director buffer, sixteen 32-bit entries with full and empty flags
`timescale 1ns/10ps
module dpu_dbuf (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clr,
  input wire logic we_hi,
  input wire logic we_lo,
  input wire logic [dpu_pkg::WORD_W-1:0] wdata,
  input wire logic adv_in,
  input wire logic adv_out,
  output logic [dpu_pkg::DIR_W-1:0] rdata,
  output logic [dpu_pkg::PTR_W-1:0] in_ptr,
  output logic [dpu_pkg::PTR_W-1:0] out_ptr,
  output logic full,
  output logic empty
);
  typedef struct packed {
    logic [dpu_pkg::PTR_W-1:0] in_ptr;
    logic [dpu_pkg::PTR_W-1:0] out_ptr;
    logic full;
    logic empty;
  } dpu_bst_t;

  dpu_bst_t st_ff;
  dpu_bst_t nxt_st;
  logic [dpu_pkg::DIR_W-1:0] mem [dpu_pkg::BUF_DEPTH];
  logic in_ok;
  logic out_ok;

  always_ff @(posedge mclk) begin
    if (we_hi && !st_ff.full) begin
      mem[st_ff.in_ptr][31:16] <= wdata;
    end
    if (we_lo && !st_ff.full) begin
      mem[st_ff.in_ptr][15:0] <= wdata;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    // a full buffer freezes the input side, an empty one the output side
    in_ok = adv_in && !st_ff.full;
    out_ok = adv_out && !st_ff.empty;
    if (in_ok) begin
      nxt_st.in_ptr = st_ff.in_ptr + 4'h1;
    end
    if (out_ok) begin
      nxt_st.out_ptr = st_ff.out_ptr + 4'h1;
    end
    // flags set by the increment that makes the pointers equal
    if (in_ok && !out_ok) begin
      nxt_st.full = (st_ff.in_ptr + 4'h1) == st_ff.out_ptr;
      nxt_st.empty = 1'b0;
    end else if (out_ok && !in_ok) begin
      nxt_st.empty = (st_ff.out_ptr + 4'h1) == st_ff.in_ptr;
      nxt_st.full = 1'b0;
    end
    if (clr) begin
      nxt_st = '0;
      nxt_st.empty = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '{in_ptr: 4'h0, out_ptr: 4'h0, full: 1'b0, empty: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = mem[st_ff.out_ptr];
  assign in_ptr = st_ff.in_ptr;
  assign out_ptr = st_ff.out_ptr;
  assign full = st_ff.full;
  assign empty = st_ff.empty;
endmodule

// [bench/dpu_mem.sv]
// Behavioural shared core memory answering the unit's references
`timescale 1ns/10ps
module dpu_mem (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic mem_req,
  input wire logic [dpu_pkg::MEM_AW-1:0] mem_addr,
  output logic mem_ack,
  output logic [dpu_pkg::WORD_W-1:0] mem_rdata
);
  logic [dpu_pkg::WORD_W-1:0] mem [0:4095];
  int lat = 0;
  int cnt;

  // Data lines toggle outside the reply cycle so a stale word never looks valid
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h5A5A;
      cnt <= 0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && cnt >= lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr];
      cnt <= 0;
    end else begin
      cnt <= mem_req ? cnt + 1 : 0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// [bench/dpu_checker.sv]
// Port-level assertions for the director prefetch unit
`timescale 1ns/10ps
module dpu_checker (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_req,
  input wire logic [dpu_pkg::MEM_AW-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [dpu_pkg::WORD_W-1:0] mem_rdata,
  input wire logic proc_req,
  input wire logic [dpu_pkg::ADDR_W-1:0] proc_addr,
  input wire logic proc_ack,
  input wire logic [dpu_pkg::WORD_W-1:0] proc_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic st_rd;
  assign st_rd = pready && !pwrite && paddr == dpu_pkg::OFS_STATUS;

  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer one cycle after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  read_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  flag_ptr_a: assert property (st_rd && (prdata[8] || prdata[9]) |-> prdata[3:0] == prdata[7:4])
    else $error("flag set with unequal pointers");
  flag_excl_a: assert property (st_rd |-> !(prdata[8] && prdata[9]))
    else $error("full and empty together");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request or address moved");
  mem_drop_a: assert property (mem_ack |=> !mem_req)
    else $error("request kept after reply");
  proc_addr_a: assert property (proc_ack |-> $past(mem_addr) == $past(proc_addr[11:0]))
    else $error("processor reference used wrong address");
  proc_pulse_a: assert property (proc_ack |-> $past(mem_ack) ##1 !proc_ack)
    else $error("processor ack not tied to reply");
  proc_wait_a: assert property ($rose(proc_req) |-> ##[1:300] proc_ack)
    else $error("processor reference starved");
endmodule

bind dpu_top dpu_checker dpu_checker_inst (
  .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
  .proc_req(proc_req), .proc_addr(proc_addr), .proc_ack(proc_ack),
  .proc_rdata(proc_rdata));

// [bench/testbench.sv]
// Self-checking bench for the director prefetch unit
`timescale 1ns/10ps
module testbench;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic proc_req = 1'b0;
  logic [15:0] proc_addr = 16'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, mem_req, mem_ack, proc_ack, err;
  logic [11:0] mem_addr;
  logic [15:0] mem_rdata, proc_rdata;
  logic [3:0] p;
  int errors = 0;
  int tests_run = 0;

  always #25 mclk = ~mclk;

  dpu_top dpu_top_inst (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .proc_req(proc_req), .proc_addr(proc_addr),
    .proc_ack(proc_ack), .proc_rdata(proc_rdata));
  dpu_mem dpu_mem_inst (.mclk(mclk), .arst_n(arst_n), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic func(input logic [15:0] code);
    apb(1'b1, dpu_pkg::OFS_FUNC, {16'h0, code});
  endtask

  task automatic rdreg(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  // Polls status until the masked field settles, bounded
  task automatic wait_st(input logic [31:0] mask, input logic [31:0] val);
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, dpu_pkg::OFS_STATUS, 32'h0);
      if ((rd & mask) === val) break;
    end
    check("status", rd & mask, val);
  endtask

  task automatic load_mem(input int a, input logic [15:0] w[$]);
    foreach (w[i]) dpu_mem_inst.mem[a + i] = w[i];
  endtask

  task automatic proc_read(input logic [15:0] a, input logic [15:0] exp);
    proc_req <= 1'b1;
    proc_addr <= a;
    do @(posedge mclk); while (proc_ack !== 1'b1);
    proc_req <= 1'b0;
    check("proc data", {16'h0, proc_rdata}, {16'h0, exp});
  endtask

  task automatic reset_values;
    rdreg(dpu_pkg::OFS_STATUS, 32'h0000_0100, "status");
    rdreg(dpu_pkg::OFS_DIR_ADDR, 32'h0, "dir addr");
    apb(1'b1, 8'h18, 32'hFFFF);
    check("unmapped err", {31'h0, err}, 32'h1);
    rdreg(8'h18, 32'h0, "unmapped rd");
    check("unmapped rd err", {31'h0, err}, 32'h1);
  endtask

  // Branch, terminate and stop words; the second stop resumes from the held address
  task automatic branches;
    load_mem(0, '{16'h0001, 16'h0100});
    load_mem(256, '{16'h0002, 16'h0200, 16'h0004, 16'h0003});
    func(dpu_pkg::FN_LOAD);
    wait_st(32'h0000_0400, 32'h0);
    check("in ptr", rd & 32'h0000_03FF, 32'h0000_0002);
    rdreg(dpu_pkg::OFS_DIR_ADDR, 32'h0000_0104, "dir stop");
    func(dpu_pkg::FN_EXEC);
    wait_st(32'h0000_01FF, 32'h0000_0122);
    rdreg(dpu_pkg::OFS_COND_ADDR, 32'h0000_0200, "cond addr");
    rdreg(dpu_pkg::OFS_DIR_ADDR, 32'h0000_0104, "dir held");
    apb(1'b1, dpu_pkg::OFS_EXEC_CTRL, 32'h1 << dpu_pkg::EXC_COND_BIT);
    rdreg(dpu_pkg::OFS_DIR_ADDR, 32'h0000_0200, "dir taken");
    load_mem(512, '{16'h0003});
    func(dpu_pkg::FN_LOAD);
    wait_st(32'h0000_0400, 32'h0);
    rdreg(dpu_pkg::OFS_DIR_ADDR, 32'h0000_0201, "dir reload");
    func(dpu_pkg::FN_MCLEAR);
    rdreg(dpu_pkg::OFS_DIR_ADDR, 32'h0, "dir clear");
    rdreg(dpu_pkg::OFS_FUNC, {16'h0, dpu_pkg::FN_MCLEAR}, "func code");
    apb(1'b0, dpu_pkg::OFS_STATUS, 32'h0);
    check("clear flags", rd & 32'h0000_0300, 32'h0000_0100);
  endtask

  // Data address word carries the stop code, so a decode slip would halt loading
  task automatic addr_data;
    apb(1'b0, dpu_pkg::OFS_STATUS, 32'h0);
    p = rd[3:0] + 4'h4;
    load_mem(0, '{16'h0005, 16'h1111, 16'h0003, 16'h2222,
      16'h0006, 16'h0002, 16'h0004, 16'h0003});
    func(dpu_pkg::FN_EXEC);
    func(dpu_pkg::FN_LOAD);
    wait_st(32'h0000_45FF, {24'h0, p, p} | 32'h0000_0100);
    rdreg(dpu_pkg::OFS_DATA_ADDR, 32'h0000_0005, "data addr");
    rdreg(dpu_pkg::OFS_EXEC_CTRL, 32'h0, "words left");
    rdreg(dpu_pkg::OFS_DIR_ADDR, 32'h0000_0008, "dir seq");
  endtask

  // Slow memory, full buffer, processor reference, then pipelined staging
  task automatic fill_full;
    apb(1'b0, dpu_pkg::OFS_STATUS, 32'h0);
    p = rd[3:0];
    for (int i = 0; i < 32; i++) load_mem(8 + i, '{i[0] ? 16'hA000 + 16'(i) : 16'h0007});
    load_mem(40, '{16'h0003});
    dpu_mem_inst.lat = 2;
    func(dpu_pkg::FN_LOAD);
    wait_st(32'h0000_03FF, {24'h0, p, p} | 32'h0000_0200);
    rdreg(dpu_pkg::OFS_DIR_ADDR, 32'h0000_0028, "dir full");
    proc_read(16'hF009, 16'hA001);
    func(dpu_pkg::FN_EXEC);
    wait_st(32'h0000_00F0, {24'h0, p + 4'h2, 4'h0});
    rdreg(dpu_pkg::OFS_OUT_REG, 32'h0007_A003, "staged");
    apb(1'b1, dpu_pkg::OFS_EXEC_CTRL, 32'h1 << dpu_pkg::EXC_DONE_BIT);
    wait_st(32'h0000_00F0, {24'h0, p + 4'h3, 4'h0});
    rdreg(dpu_pkg::OFS_OUT_REG, 32'h0007_A005, "next staged");
  endtask

  task automatic stop_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    errors++;
    stop_test;
  end

  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    reset_values;
    branches;
    addr_data;
    fill_full;
    stop_test;
  end
endmodule
